// >>> rtl/i2cgc_pkg.sv
package i2cgc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BUFFER = 8'h13;
    localparam logic [7:0] IDX_CONTROL = 8'h14;
    localparam logic [7:0] IDX_OWN_ADDR = 8'h15;
    localparam logic [7:0] IDX_CONTROL2 = 8'h16;
    localparam logic [7:0] IDX_STATUS = 8'h17;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h18;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h19;

    // serial_port_control fields
    localparam int CTL_OVF_BIT = 6;
    localparam int CTL_EN_BIT = 5;
    localparam int CTL_MODE_LSB = 0;
    localparam logic [3:0] MODE_SLAVE_7BIT = 4'h6;
    localparam logic [3:0] MODE_SLAVE_10BIT = 4'h7;

    // second_serial_control fields
    localparam int CTL2_GENERAL_CALL_ENABLE_BIT = 7;

    // serial_status_reg fields
    localparam int STA_BF_BIT = 0;
    localparam int STA_UA_BIT = 1;
    localparam int STA_GC_BIT = 2;

    // interrupt status / mask fields
    localparam int IRQ_BYTE_BIT = 0;
    localparam int IRQ_STOP_BIT = 1;

    // reset values
    localparam logic [7:0] RST_BUFFER = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_CONTROL2 = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // fixed general call byte, address zero with write direction
    localparam logic [7:0] GENERAL_CALL_BYTE = 8'h00;
    localparam logic [4:0] TEN_BIT_HEADER = 5'h1E;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_ACK = 2'b11,
        ST_WAIT = 2'b10
    } i2cgc_state_t;

endpackage

// >>> rtl/i2cgc_pin_sync.sv
`timescale 1ns/1ps
module i2cgc_pin_sync #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] pinRaw,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // two flops, then a third for edge finding
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stage1 <= '1;
            stage2 <= '1;
            stage3 <= '1;
        end else begin
            stage1 <= pinRaw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;

endmodule // i2cgc_pin_sync

// >>> rtl/i2cgc_addr_match.sv
`timescale 1ns/1ps
module i2cgc_addr_match
    import i2cgc_pkg::*;
(
    input wire logic [7:0] addrByte,
    input wire logic [7:0] ownAddress,
    input wire logic generalCallEnable,
    input wire logic tenBitMode,
    input wire logic secondHalf,
    output logic generalCallHit,
    output logic ownHit
);
    logic firstHit;

    // first byte: upper seven bits match, write direction only
    assign firstHit = (addrByte[7:1] == ownAddress[7:1]) && !addrByte[0]
        && (!tenBitMode || addrByte[7:3] == TEN_BIT_HEADER);
    assign ownHit = secondHalf ? (addrByte == ownAddress) : firstHit;
    // hardwired compare, independent of own address
    // all-zero byte, write direction
    assign generalCallHit = generalCallEnable && !secondHalf && (addrByte == GENERAL_CALL_BYTE);

endmodule // i2cgc_addr_match

// >>> rtl/i2cgc_slave.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - first byte after start selects slave
// - general call is all-zero, write direction
// - general call only when enable bit set
// - shift eight bits, compare own address
// - also compare with hardwired general call
// - match loads buffer, sets buffer-full
// - interrupt flag at ninth clock fall
// - ten-bit match sets update-address flag
// - ten-bit general call skips second half
module i2cgc_slave
    import i2cgc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic irq
);
    // synchronised pin levels and edges
    logic [1:0] pinLevel;
    logic [1:0] pinRise;
    logic [1:0] pinFall;
    logic sclHigh;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    // software-visible state
    logic [7:0] receiveBuffer;
    logic [7:0] control;
    logic [7:0] ownAddress;
    logic [7:0] control2;
    logic [7:0] irqStatus;
    logic [7:0] irqMask;
    logic bufferFull;
    logic updateAddress;
    logic lastWasGc;

    // byte engine
    i2cgc_state_t state;
    logic [7:0] addressShift;
    logic [3:0] bitCount;
    logic inAddress;
    logic secondHalf;
    logic ackThis;
    logic toData;
    logic byteDone;

    logic [7:0] nextShift;
    logic gcHit;
    logic ownHit;
    logic enabled;
    logic tenBit;
    logic eighthBit;
    logic addrHit;
    logic ninthEnd;

    // register bus decode
    logic access;
    logic doWrite;
    logic doRead;
    logic mapped;
    logic [7:0] readValue;
    logic selBuffer;
    logic selControl;
    logic selOwnAddr;
    logic selControl2;
    logic selStatus;
    logic selIrqStatus;
    logic selIrqMask;

    function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [7:0] index);
        isReg = addr == ADDR_W'({index, 2'b00});
    endfunction

    i2cgc_pin_sync #(
        .W(2)
    ) pinSync (
        .clock(clock),
        .rstn(rstn),
        .pinRaw({sclIn, sdaIn}),
        .level(pinLevel),
        .rise(pinRise),
        .fall(pinFall)
    );

    assign sclHigh = pinLevel[1];
    assign sclRise = pinRise[1];
    assign sclFall = pinFall[1];
    assign startSeen = pinFall[0] && sclHigh;
    assign stopSeen = pinRise[0] && sclHigh;

    assign enabled = control[CTL_EN_BIT]
        && (control[3:0] == MODE_SLAVE_7BIT || control[3:0] == MODE_SLAVE_10BIT);
    assign tenBit = control[3:0] == MODE_SLAVE_10BIT;
    assign nextShift = {addressShift[6:0], pinLevel[0]};

    // hardwired and own compare side by side
    i2cgc_addr_match addrMatch (
        .addrByte(nextShift),
        .ownAddress(ownAddress),
        .generalCallEnable(control2[CTL2_GENERAL_CALL_ENABLE_BIT]),
        .tenBitMode(tenBit),
        .secondHalf(secondHalf),
        .generalCallHit(gcHit),
        .ownHit(ownHit)
    );

    // eighth sampled bit completes the byte
    assign eighthBit = (state == ST_SHIFT) && sclRise && (bitCount == BITS_PER_BYTE - 4'h1);
    // only an addressed slave takes part
    assign addrHit = gcHit || ownHit;
    assign ninthEnd = (state == ST_ACK) && sclFall;

    // bus framing and byte state machine
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= ST_IDLE;
            bitCount <= 4'h0;
            addressShift <= 8'h00;
            inAddress <= 1'b0;
            secondHalf <= 1'b0;
            ackThis <= 1'b0;
            toData <= 1'b0;
            byteDone <= 1'b0;
        end else if (!enabled || stopSeen) begin
            state <= ST_IDLE;
            bitCount <= 4'h0;
            inAddress <= 1'b0;
            secondHalf <= 1'b0;
            byteDone <= 1'b0;
        end else if (startSeen) begin
            // first byte after start is the address
            state <= ST_SHIFT;
            bitCount <= 4'h0;
            inAddress <= 1'b1;
            secondHalf <= 1'b0;
            byteDone <= 1'b0;
        end else begin
            case (state)
                ST_SHIFT: begin
                    if (sclRise) begin
                        addressShift <= nextShift;
                        bitCount <= bitCount + 4'h1;
                    end
                    if (eighthBit) begin
                        byteDone <= 1'b1;
                        if (inAddress) begin
                            ackThis <= addrHit;
                            // ten-bit general call goes straight to data
                            toData <= gcHit || !tenBit || secondHalf;
                        end else begin
                            ackThis <= !bufferFull;
                            toData <= 1'b1;
                        end
                    end
                    if (byteDone && sclFall) begin
                        byteDone <= 1'b0;
                        state <= (inAddress && !ackThis) ? ST_IDLE : ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        bitCount <= 4'h0;
                        state <= ST_SHIFT;
                        if (inAddress && !toData) begin
                            secondHalf <= 1'b1;
                        end else begin
                            inAddress <= 1'b0;
                            secondHalf <= 1'b0;
                        end
                    end
                end
                ST_WAIT: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // hold data low through the ninth clock
    assign sdaOut = 1'b0;
    assign sdaOe = (state == ST_ACK) && ackThis;

    assign access = psel && penable && pready;
    assign doWrite = access && pwrite;
    assign doRead = access && !pwrite;
    // one select per register word
    assign selBuffer = isReg(paddr, IDX_BUFFER);
    assign selControl = isReg(paddr, IDX_CONTROL);
    assign selOwnAddr = isReg(paddr, IDX_OWN_ADDR);
    assign selControl2 = isReg(paddr, IDX_CONTROL2);
    assign selStatus = isReg(paddr, IDX_STATUS);
    assign selIrqStatus = isReg(paddr, IDX_IRQ_STATUS);
    assign selIrqMask = isReg(paddr, IDX_IRQ_MASK);
    assign mapped = selBuffer || selControl || selOwnAddr || selControl2 || selStatus || selIrqStatus
        || selIrqMask;

    // receive buffer and buffer-full flag
    always_ff @(posedge clock) begin
        if (!rstn) begin
            receiveBuffer <= RST_BUFFER;
            bufferFull <= 1'b0;
            lastWasGc <= 1'b0;
        end else begin
            if (doWrite && isReg(paddr, IDX_BUFFER)) begin
                receiveBuffer <= pwdata[7:0];
            end else if (doRead && isReg(paddr, IDX_BUFFER)) begin
                bufferFull <= 1'b0;
            end
            // matched byte lands in buffer at eighth bit
            if (eighthBit && ((inAddress && addrHit) || (!inAddress && !bufferFull))) begin
                receiveBuffer <= nextShift;
                bufferFull <= 1'b1;
                if (inAddress) begin
                    lastWasGc <= gcHit;
                end
            end
        end
    end

    // control registers and overflow flag
    always_ff @(posedge clock) begin
        if (!rstn) begin
            control <= RST_CONTROL;
            control2 <= RST_CONTROL2;
            ownAddress <= RST_OWN_ADDR;
            irqMask <= RST_IRQ_MASK;
        end else begin
            if (doWrite && isReg(paddr, IDX_CONTROL)) begin
                control <= pwdata[7:0];
            end
            // general call enable steers the matcher
            if (doWrite && isReg(paddr, IDX_CONTROL2)) begin
                control2 <= pwdata[7:0];
            end
            // software rewrites own address between halves
            if (doWrite && isReg(paddr, IDX_OWN_ADDR)) begin
                ownAddress <= pwdata[7:0];
            end
            if (doWrite && isReg(paddr, IDX_IRQ_MASK)) begin
                irqMask <= pwdata[7:0];
            end
            // data byte arriving while the buffer is full
            if (eighthBit && !inAddress && bufferFull) begin
                control[CTL_OVF_BIT] <= 1'b1;
            end
        end
    end

    // update-address flag
    always_ff @(posedge clock) begin
        if (!rstn) begin
            updateAddress <= 1'b0;
        end else if (eighthBit && inAddress && tenBit && ownHit && !gcHit) begin
            // ten-bit own match asks for address update
            updateAddress <= 1'b1;
        end else if (doWrite && isReg(paddr, IDX_OWN_ADDR)) begin
            updateAddress <= 1'b0;
        end
    end

    // sticky interrupt status, cleared by read, set wins
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irqStatus <= 8'h00;
        end else begin
            if (doRead && isReg(paddr, IDX_IRQ_STATUS)) begin
                irqStatus <= 8'h00;
            end
            // flag on falling edge ending the ninth bit
            if (ninthEnd) begin
                irqStatus[IRQ_BYTE_BIT] <= 1'b1;
            end
            if (stopSeen && enabled && state != ST_IDLE) begin
                irqStatus[IRQ_STOP_BIT] <= 1'b1;
            end
        end
    end

    // level interrupt from unmasked sticky bits
    assign irq = |(irqStatus & irqMask);

    // buffer readback lets software tell the address source
    always_comb begin
        readValue = 8'h00;
        if (isReg(paddr, IDX_BUFFER)) begin
            readValue = receiveBuffer;
        end else if (isReg(paddr, IDX_CONTROL)) begin
            readValue = control;
        end else if (isReg(paddr, IDX_OWN_ADDR)) begin
            readValue = ownAddress;
        end else if (isReg(paddr, IDX_CONTROL2)) begin
            readValue = control2;
        end else if (isReg(paddr, IDX_STATUS)) begin
            readValue[STA_BF_BIT] = bufferFull;
            readValue[STA_UA_BIT] = updateAddress;
            readValue[STA_GC_BIT] = lastWasGc;
        end else if (isReg(paddr, IDX_IRQ_STATUS)) begin
            readValue = irqStatus;
        end else if (isReg(paddr, IDX_IRQ_MASK)) begin
            readValue = irqMask;
        end
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, readValue};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // i2cgc_slave

// >>> bench/i2cgc_slave_sva.sv
`timescale 1ns/1ps
module i2cgc_slave_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    error_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    write_reads_zero_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data");
    open_drain_a: assert property (sdaOut == 1'b0) else $error("sdaOut high");
    ack_scl_low_a: assert property ($changed(sdaOe) |-> !sclIn) else $error("ack moved");
    ack_span_a: assert property ($rose(sdaOe) |-> sdaOe [*8]) else $error("ack short");
    ack_release_a: assert property ($fell(sdaOe) |-> !sdaOe [*4]) else $error("ack again");
    irq_clear_a: assert property ($fell(irq) |-> $past(pready)) else $error("irq dropped");
endmodule // i2cgc_slave_sva

bind i2cgc_slave i2cgc_slave_sva #(.ADDR_W(ADDR_W)) chk (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .irq(irq));

// >>> bench/i2cgc_bus_master.sv
`timescale 1ns/1ps
module i2cgc_bus_master (
    input wire logic clock,
    output logic scl,
    output logic sda,
    input wire logic sdaLine
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic wait5();
        repeat (5) @(posedge clock);
    endtask
    task automatic sendStart();
        @(posedge clock);
        sda <= 1'b0;
        wait5();
        scl <= 1'b0;
        wait5();
    endtask
    task automatic bitOut(input logic b, output logic s);
        sda <= b;
        wait5();
        scl <= 1'b1;
        wait5();
        @(negedge clock);
        s = sdaLine;
        wait5();
        scl <= 1'b0;
        wait5();
    endtask
    // msb first, line released for ack
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitOut(b[i], s);
        bitOut(1'b1, s);
        ack = !s;
    endtask
    task automatic sendStop();
        sda <= 1'b0;
        wait5();
        scl <= 1'b1;
        wait5();
        sda <= 1'b1;
        wait5();
        wait5();
    endtask
endmodule // i2cgc_bus_master

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    import i2cgc_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sdaOut, sdaOe, irq, scl, sdaM, sdaLine, ack, err;
    logic [7:0] rd;
    int failures = 0;
    int checks = 0;
    // pull-up on the data line
    assign sdaLine = sdaM & (sdaOe ? sdaOut : 1'b1);
    i2cgc_slave uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
    i2cgc_bus_master mdl (.clock(clock), .scl(scl), .sda(sdaM), .sdaLine(sdaLine));
    initial forever #4 clock = ~clock;
    task automatic report_and_stop();
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) check("pready", 8'h01, 8'h00);
    endtask
    task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00);
        check(name, exp, rd);
    endtask
    task automatic addrCase(input logic [7:0] ctl, ctl2, own, msk, addr, input logic expAck,
        input logic [7:0] expSt);
        apb(IDX_CONTROL, 1'b1, ctl);
        apb(IDX_CONTROL2, 1'b1, ctl2);
        apb(IDX_OWN_ADDR, 1'b1, own);
        apb(IDX_IRQ_MASK, 1'b1, msk);
        mdl.sendStart();
        mdl.sendByte(addr, ack);
        @(negedge clock);
        check("ack", {7'h0, expAck}, {7'h0, ack});
        check("irq", {7'h0, expAck & msk[0]}, {7'h0, irq});
        apb(IDX_STATUS, 1'b0, 8'h00);
        check("status", expSt, rd & (expAck ? 8'h07 : 8'h01));
        if (expAck) rdchk("address byte", IDX_BUFFER, addr);
        if (expAck && !expSt[STA_UA_BIT]) begin
            mdl.sendByte(8'hA5, ack);
            check("data ack", 8'h01, {7'h0, ack});
            rdchk("data", IDX_BUFFER, 8'hA5);
        end
        mdl.sendStop();
        apb(IDX_IRQ_STATUS, 1'b0, 8'h00);
        check("irq status", {7'h0, expAck}, {7'h0, rd[IRQ_BYTE_BIT]});
        @(negedge clock);
        check("irq cleared", 8'h00, {7'h0, irq});
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rdchk("control", IDX_CONTROL, RST_CONTROL);
        rdchk("own address", IDX_OWN_ADDR, RST_OWN_ADDR);
        rdchk("control2", IDX_CONTROL2, RST_CONTROL2);
        rdchk("mask", IDX_IRQ_MASK, RST_IRQ_MASK);
        apb(8'h20, 1'b0, 8'h00);
        check("slverr", 8'h01, {7'h0, err});
        apb(IDX_BUFFER, 1'b1, 8'h5A);
        rdchk("buffer", IDX_BUFFER, 8'h5A);
        addrCase(8'h26, 8'h00, 8'h50, 8'h01, 8'h00, 1'b0, 8'h00);
        addrCase(8'h26, 8'h80, 8'h50, 8'h01, 8'h00, 1'b1, 8'h05);
        addrCase(8'h26, 8'h80, 8'h50, 8'h01, 8'h01, 1'b0, 8'h00);
        addrCase(8'h26, 8'h80, 8'h50, 8'h00, 8'h50, 1'b1, 8'h01);
        addrCase(8'h27, 8'h80, 8'hF0, 8'h01, 8'h00, 1'b1, 8'h05);
        addrCase(8'h27, 8'h80, 8'hF0, 8'h01, 8'hF0, 1'b1, 8'h03);
        mdl.sendStart();
        mdl.sendByte(8'hF0, ack);
        check("first half ack", 8'h01, {7'h0, ack});
        apb(IDX_OWN_ADDR, 1'b1, 8'h3C);
        rdchk("update cleared", IDX_STATUS, 8'h01);
        rdchk("first half", IDX_BUFFER, 8'hF0);
        mdl.sendByte(8'h3C, ack);
        check("second half ack", 8'h01, {7'h0, ack});
        rdchk("second half", IDX_STATUS, 8'h03);
        mdl.sendByte(8'h66, ack);
        check("full nack", 8'h00, {7'h0, ack});
        rdchk("overflow", IDX_CONTROL, 8'h67);
        mdl.sendStop();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        check("irq after reset", 8'h00, {7'h0, irq});
        rdchk("control2 again", IDX_CONTROL2, RST_CONTROL2);
        rdchk("irq status again", IDX_IRQ_STATUS, 8'h00);
        report_and_stop();
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule // tb
